/* File: rtl/sbcd_decoder.sv */
// Keypad start/stop/jog decode into motor sequencing commands.
// Assumes the sequencer reports accel and stop completion as pulses.
//
// Operation
// - Start press begins acceleration to full speed under every option, unless a stop is in progress or pressed with it while the motor runs.
// - Stop press removes drive for a coast stop under every option.
// - Gradual-stop option: jog press runs a gradual stop.
// - Pump option: jog press runs the pump stop.
// - Preset slow option: jog while stopped starts slow-speed running.
// - Braking option: jog press runs a braked stop.
// - Positioning: jog stopped starts slow; at speed brakes to slow.
// - Positioning: slow speed lasts only while jog stays held.
// - Slow with braking: jog stopped starts slow; at speed brakes stop.
// - One option held at a time; decode follows that option only.
// - Buttons are ignored until keypad control is enabled.
`timescale 1ns/1ps
module sbcd_decoder
    import sbcd_pkg::*;
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       start_btn_in,
    input  wire logic       stop_btn_in,
    input  wire logic       jog_btn_in,
    input  wire logic       ctrl_enable_in,
    input  wire logic [2:0] option_in,
    input  wire logic       option_load_in,
    input  wire logic       accel_done_in,
    input  wire logic       stop_done_in,
    output logic            accel_cmd_out,
    output logic            slow_cmd_out,
    output logic [2:0]      stop_kind_out,
    output logic [2:0]      motor_state_out,
    output logic [2:0]      option_out
);

    logic [BTN_COUNT-1:0] btn_level;
    logic [BTN_COUNT-1:0] btn_press;
    logic                 en_meta_ff;
    logic                 en_ff;
    sbcd_option_type      option_ff;
    sbcd_motor_type       state_ff;
    sbcd_motor_type       nxt_state;
    logic [2:0]           nxt_stop;
    logic                 accel_ff;
    logic                 slow_ff;
    logic [2:0]           stop_ff;

    // Assertions share one clock and are off while reset is low.
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sbcd_btn_sync #(.WIDTH(BTN_COUNT)) sbcd_btn_sync_inst (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .btn_in     ({jog_btn_in, stop_btn_in, start_btn_in}),
        .level_out  (btn_level),
        .press_out  (btn_press)
    );

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            en_meta_ff <= 1'b0;
            en_ff      <= 1'b0;
        end
        else
        begin
            en_meta_ff <= ctrl_enable_in;
            en_ff      <= en_meta_ff;
        end
    end

    // A single option register: loading a legal code (0 to 5) replaces the previous one.
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            option_ff <= sbcd_option_type'(OPTION_RESET);
        else if (option_load_in && option_in <= 3'h5)
            option_ff <= sbcd_option_type'(option_in);
    end

    // Presses count only once keypad control is enabled.
    wire start_p = btn_press[BTN_START] & en_ff;
    wire stop_p  = btn_press[BTN_STOP]  & en_ff;
    wire jog_p   = btn_press[BTN_JOG]   & en_ff;
    wire jog_hld = btn_level[BTN_JOG];
    // A jog press that neither stop nor start overrides this cycle.
    wire jog_only = jog_p & ~stop_p & ~start_p;

    // Jog-to-stop kind for the options whose jog stops the motor, slow with braking included.
    wire [2:0] jog_stop_kind =
        (option_ff == OPT_GRADUAL_STOP) ? STOP_GRADUAL :
        (option_ff == OPT_PUMP)         ? STOP_PUMP    :
        (option_ff == OPT_BRAKING)      ? STOP_BRAKE   :
        (option_ff == OPT_SLOW_BRAKE)   ? STOP_BRAKE   :
                                          STOP_NONE;
    wire slow_opt = (option_ff == OPT_PRESET_SLOW) ||
                    (option_ff == OPT_POSITIONING) ||
                    (option_ff == OPT_SLOW_BRAKE);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_stop  = stop_ff;
        if (stop_p && state_ff != MOT_STOPPED)
        begin
            nxt_state = MOT_STOPPING;
            nxt_stop  = STOP_COAST;
        end
        else if (start_p && state_ff != MOT_STOPPING)
        begin
            nxt_state = MOT_ACCEL;
            nxt_stop  = STOP_NONE;
        end
        else
        begin
            unique case (state_ff)
                MOT_STOPPED:
                    if (jog_p && slow_opt)
                        nxt_state = MOT_SLOW;
                MOT_ACCEL:
                    if (accel_done_in)
                        nxt_state = MOT_AT_SPEED;
                    else if (jog_p && jog_stop_kind != STOP_NONE)
                    begin
                        nxt_state = MOT_STOPPING;
                        nxt_stop  = jog_stop_kind;
                    end
                MOT_AT_SPEED:
                    if (jog_p && option_ff == OPT_POSITIONING)
                    begin
                        nxt_state = MOT_SLOW;
                        nxt_stop  = STOP_TO_SLOW;
                    end
                    else if (jog_p && jog_stop_kind != STOP_NONE)
                    begin
                        nxt_state = MOT_STOPPING;
                        nxt_stop  = jog_stop_kind;
                    end
                MOT_SLOW:
                    if (option_ff == OPT_POSITIONING && !jog_hld)
                    begin
                        nxt_state = MOT_STOPPED;
                        nxt_stop  = STOP_NONE;
                    end
                MOT_STOPPING:
                    if (stop_done_in)
                    begin
                        nxt_state = MOT_STOPPED;
                        nxt_stop  = STOP_NONE;
                    end
            endcase
            // Any other jog leaves the state as it is.
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_ff <= MOT_STOPPED;
            stop_ff  <= STOP_NONE;
            accel_ff <= 1'b0;
            slow_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            stop_ff  <= nxt_stop;
            accel_ff <= (nxt_state == MOT_ACCEL);
            slow_ff  <= (nxt_state == MOT_SLOW);
        end
    end

    assign accel_cmd_out   = accel_ff;
    assign slow_cmd_out    = slow_ff;
    assign stop_kind_out   = stop_ff;
    assign motor_state_out = state_ff;
    assign option_out      = option_ff;

    AST_START_ACCEL: assert property (
        (start_p && state_ff == MOT_STOPPED && !stop_p) |=> accel_cmd_out)
        else $error("Start press did not begin acceleration.");

    AST_STOP_COAST: assert property (
        (stop_p && state_ff != MOT_STOPPED)
        |=> (stop_kind_out == STOP_COAST && !accel_cmd_out))
        else $error("Stop press did not give a coast stop.");

    AST_JOG_GRADUAL: assert property (
        (jog_only && state_ff == MOT_AT_SPEED &&
         option_ff == OPT_GRADUAL_STOP)
        |=> stop_kind_out == STOP_GRADUAL)
        else $error("Jog did not start a gradual stop.");

    AST_JOG_PUMP: assert property (
        (jog_only && state_ff == MOT_AT_SPEED && option_ff == OPT_PUMP)
        |=> stop_kind_out == STOP_PUMP)
        else $error("Jog did not start a pump stop.");

    AST_JOG_SLOW: assert property (
        (jog_only && state_ff == MOT_STOPPED && slow_opt)
        |=> slow_cmd_out)
        else $error("Jog while stopped did not start slow speed.");

    AST_JOG_BRAKE: assert property (
        (jog_only && state_ff == MOT_AT_SPEED && option_ff == OPT_BRAKING)
        |=> stop_kind_out == STOP_BRAKE)
        else $error("Jog did not start a braked stop.");

    AST_POS_TO_SLOW: assert property (
        (jog_only && state_ff == MOT_AT_SPEED &&
         option_ff == OPT_POSITIONING)
        |=> (slow_cmd_out && stop_kind_out == STOP_TO_SLOW))
        else $error("Jog at speed did not brake to slow speed.");

    AST_POS_RELEASE: assert property (
        (state_ff == MOT_SLOW && option_ff == OPT_POSITIONING &&
         !jog_hld && !stop_p && !start_p)
        |=> !slow_cmd_out)
        else $error("Slow speed held after jog release.");

    AST_SLOW_BRAKE: assert property (
        (jog_only && state_ff == MOT_AT_SPEED &&
         option_ff == OPT_SLOW_BRAKE)
        |=> stop_kind_out == STOP_BRAKE)
        else $error("Jog at speed did not start a braked stop.");

    AST_OPTION_KEPT: assert property (
        (option_load_in && option_in > 3'h5) |=> $stable(option_out))
        else $error("Illegal option code replaced the held option.");

    AST_NOT_ENABLED: assert property (
        (!en_ff && state_ff == MOT_STOPPED && !accel_done_in)
        |=> state_ff == MOT_STOPPED)
        else $error("Button acted on before control was enabled.");

    AST_JOG_IGNORED: assert property (
        (jog_only && state_ff == MOT_STOPPED && !slow_opt)
        |=> motor_state_out == MOT_STOPPED)
        else $error("Jog with no meaning changed the motor state.");

endmodule : sbcd_decoder

/* File: rtl/sbcd_pkg.sv */
// Constants and types shared by the starter button command decoder.
// Assumes one 40 MHz system clock; buttons come from a remote keypad.
package sbcd_pkg;

    // Installed stopping or slow-speed option; only one is ever held.
    typedef enum logic [2:0] {
        OPT_GRADUAL_STOP = 3'h0,
        OPT_PUMP         = 3'h1,
        OPT_PRESET_SLOW  = 3'h2,
        OPT_BRAKING      = 3'h3,
        OPT_POSITIONING  = 3'h4,
        OPT_SLOW_BRAKE   = 3'h5
    } sbcd_option_type;

    // Motor state as seen by the decoder.
    typedef enum logic [2:0] {
        MOT_STOPPED,
        MOT_ACCEL,
        MOT_AT_SPEED,
        MOT_SLOW,
        MOT_STOPPING
    } sbcd_motor_type;

    // Stop sequence kinds handed to the motor sequencer.
    localparam logic [2:0] STOP_NONE    = 3'h0;
    localparam logic [2:0] STOP_COAST   = 3'h1;
    localparam logic [2:0] STOP_GRADUAL = 3'h2;
    localparam logic [2:0] STOP_PUMP    = 3'h3;
    localparam logic [2:0] STOP_BRAKE   = 3'h4;
    localparam logic [2:0] STOP_TO_SLOW = 3'h5;

    localparam logic [2:0] OPTION_RESET = 3'h0;
    localparam int         BTN_COUNT    = 3;
    localparam int         BTN_START    = 0;
    localparam int         BTN_STOP     = 1;
    localparam int         BTN_JOG      = 2;

endpackage : sbcd_pkg

/* File: rtl/sbcd_btn_sync.sv */
// Two-stage synchroniser and rising-edge detector for keypad buttons.
// Assumes the buttons are asynchronous to sys_clk_in and active high.
`timescale 1ns/1ps
module sbcd_btn_sync
    import sbcd_pkg::*;
#(
    parameter int WIDTH = BTN_COUNT
)
(
    input  wire logic             sys_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic [WIDTH-1:0] btn_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] press_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] prev_ff;

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end
        else
        begin
            meta_ff <= btn_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level_out = sync_ff;
    assign press_out = sync_ff & ~prev_ff;

endmodule : sbcd_btn_sync

/* File: sim/sbcd_keypad_model.sv */
// Keypad model: each one-cycle press request holds a button for 4 cycles.
// Assumes requests come from the bench just after a rising clock edge.
`timescale 1ns/1ps
module sbcd_keypad_model
(
    input  wire logic       sys_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic [2:0] press_in,
    input  wire logic       jog_hold_in,
    output logic            start_btn_out,
    output logic            stop_btn_out,
    output logic            jog_btn_out
);
    logic [3:0] hist_ff [3];

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!rst_b_in)
                hist_ff[i] <= 4'h0;
            else
                hist_ff[i] <= {hist_ff[i][2:0], press_in[i]};
        end
    end

    assign start_btn_out = |hist_ff[0];
    assign stop_btn_out  = |hist_ff[1];
    assign jog_btn_out   = (|hist_ff[2]) | jog_hold_in;
endmodule : sbcd_keypad_model

/* File: sim/starter_button_command_decoder_tb.sv */
// Self-checking bench for the button decoder with a keypad model.
// Assumes the sequencer completion pulses are played by the bench.
`timescale 1ns/1ps
module starter_button_command_decoder_tb;
    import sbcd_pkg::*;
    logic       clk = 0, rst_b = 0, en = 0, load = 0, hold = 0;
    logic       acc_d = 0, stp_d = 0, b_st, b_sp, b_jg;
    logic [2:0] press = 3'h0, opt = 3'h0, st, kind, opt_o;
    logic       acc, slow;
    int         mismatches = 0, cmp_count = 0;

    always #12.5 clk = ~clk;

    sbcd_keypad_model sbcd_keypad_model_inst (.sys_clk_in(clk),
        .rst_b_in(rst_b), .press_in(press), .jog_hold_in(hold),
        .start_btn_out(b_st), .stop_btn_out(b_sp), .jog_btn_out(b_jg));
    sbcd_decoder sbcd_decoder_inst (.sys_clk_in(clk), .rst_b_in(rst_b),
        .start_btn_in(b_st), .stop_btn_in(b_sp), .jog_btn_in(b_jg),
        .ctrl_enable_in(en), .option_in(opt), .option_load_in(load),
        .accel_done_in(acc_d), .stop_done_in(stp_d),
        .accel_cmd_out(acc), .slow_cmd_out(slow), .stop_kind_out(kind),
        .motor_state_out(st), .option_out(opt_o));

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task chk(input string name, input logic [2:0] seen, input logic [2:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task end_sim;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task push(input int i);
        press = 3'h1 << i;
        tick(1);
        press = 3'h0;
        tick(8);
    endtask : push

    task seq(input logic a, input logic s);
        acc_d = a;
        stp_d = s;
        tick(1);
        acc_d = 0;
        stp_d = 0;
        tick(2);
    endtask : seq

    task t_load(input logic [2:0] code, input logic [2:0] exp);
        opt = code;
        load = 1;
        tick(1);
        load = 0;
        tick(2);
        chk("option", opt_o, exp);
    endtask : t_load

    task t_run(input logic [2:0] o);
        logic [2:0] js [6];
        logic [2:0] jk [6];
        js = '{3'h4, 3'h4, 3'h2, 3'h4, 3'h3, 3'h4};
        jk = '{3'h2, 3'h3, 3'h0, 3'h4, 3'h5, 3'h4};
        push(BTN_START);
        chk("accel", {2'h0, acc}, 3'h1);
        chk("state", st, 3'h1);
        seq(1, 0);
        chk("state", st, 3'h2);
        // Positioning slow speed needs jog held past the short press.
        hold = (o == 3'h4);
        push(BTN_JOG);
        chk("state", st, js[o]);
        if (js[o] != 3'h2)
            chk("kind", kind, jk[o]);
        if (o == 3'h4)
        begin
            chk("slow", {2'h0, slow}, 3'h1);
            hold = 0;
            tick(4);
            chk("state", st, 3'h0);
        end
        if (o == 3'h2)
        begin
            push(BTN_STOP);
            chk("state", st, 3'h4);
            chk("kind", kind, 3'h1);
        end
        seq(0, 1);
        chk("state", st, 3'h0);
    endtask : t_run

    task t_jog_stopped(input logic [2:0] o);
        logic slow_opt;
        slow_opt = (o == 3'h2) || (o == 3'h4) || (o == 3'h5);
        push(BTN_STOP);
        chk("state", st, 3'h0);
        hold = 1;
        tick(10);
        chk("slow", {2'h0, slow}, {2'h0, slow_opt});
        chk("state", st, slow_opt ? 3'h3 : 3'h0);
        hold = 0;
        tick(6);
        if (slow_opt && o != 3'h4)
        begin
            chk("state", st, 3'h3);
            push(BTN_STOP);
            seq(0, 1);
        end
        chk("state", st, 3'h0);
    endtask : t_jog_stopped

    initial
    begin
        #1ms;
        mismatches++;
        end_sim();
    end

    initial
    begin
        tick(16);
        rst_b = 1;
        tick(2);
        chk("option", opt_o, OPTION_RESET);
        push(BTN_START);
        chk("state", st, 3'h0);
        en = 1;
        tick(4);
        for (int o = 0; o < 6; o++)
        begin
            t_load(3'(o), 3'(o));
            t_run(3'(o));
            t_jog_stopped(3'(o));
        end
        t_load(3'h7, 3'h5);
        end_sim();
    end
endmodule : starter_button_command_decoder_tb
